// >>> logic/ansc_pkg.sv
package ansc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 4;
  localparam int CLK_PERIOD_NS = 100;
  // Slowest speed grade figures, in ns.
  localparam int ADDRESS_ACCESS_TIME_NS = 35;
  localparam int ENABLE_ACCESS_TIME_NS = 35;
  localparam int WRITE_TO_HIGH_Z_TIME_NS = 13;
  localparam int WRITE_DATA_HOLD_TIME_NS = 0;
  localparam int WRITE_ADDRESS_SETUP_TIME_NS = 0;
  localparam int WRITE_PULSE_NS = 32;
  // Least times round up to whole cycles, never below one.
  localparam int ACCESS_CYC = (ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  localparam int HIZ_CYC = (WRITE_TO_HIGH_Z_TIME_NS + CLK_PERIOD_NS - 1)
                           / CLK_PERIOD_NS;
  localparam int WPULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  localparam logic [1:0] ACCESS_CNT = 2'(ACCESS_CYC < 1 ? 1 : ACCESS_CYC);
  localparam logic [1:0] HIZ_CNT = 2'(HIZ_CYC < 1 ? 1 : HIZ_CYC);
  localparam logic [1:0] WPULSE_CNT = 2'(WPULSE_CYC < 1 ? 1 : WPULSE_CYC);

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] word_address;
    logic [DATA_W-1:0] wdata;
  } ansc_req_t;

  typedef struct packed {
    logic              enable_n;
    logic              write_n;
    logic [ADDR_W-1:0] word_address;
  } ansc_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_READ  = 3'b001,
    ST_WSET  = 3'b010,
    ST_WHIZ  = 3'b011,
    ST_WPUL  = 3'b100,
    ST_WEND  = 3'b101
  } ansc_state_t;
endpackage

// >>> logic/ansc_host.sv
// Functional notes
// - Enable or write strobe stays high while address changes.
// - Address holds steady through the whole write cycle.
// - Write starts at the later falling edge of strobe or enable.
// - Write data stays valid until the strobe rises.
`timescale 1ns/1ns
module ansc_host
  import ansc_pkg::*;
(
  input  wire logic                       mclk,
  input  wire logic                       reset,
  input  wire ansc_pkg::ansc_req_t        req,
  input  wire logic                       req_valid,
  output logic                            req_ready,
  output logic [ansc_pkg::DATA_W-1:0]     rdata,
  output logic                            rdata_valid,
  output ansc_pkg::ansc_pins_t            pins,
  input  wire logic [ansc_pkg::DATA_W-1:0] dq_in,
  output logic [ansc_pkg::DATA_W-1:0]     dq_out,
  output logic                            dq_oe
);
  import ansc_pkg::*;

  ansc_state_t state;
  ansc_req_t   held;
  logic [1:0]  cnt;

  assign req_ready = (state == ST_IDLE);

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      cnt   <= 2'h0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          cnt <= 2'h1;
          if (req_valid)
            state <= req.write ? ST_WSET : ST_READ;
        end
        ST_READ:
        begin
          cnt <= cnt + 2'h1;
          if (cnt == ACCESS_CNT)
            state <= ST_IDLE;
        end
        ST_WSET:
        begin
          cnt   <= 2'h1;
          state <= ST_WHIZ;
        end
        ST_WHIZ:
        begin
          cnt <= cnt + 2'h1;
          if (cnt == HIZ_CNT)
          begin
            cnt   <= 2'h1;
            state <= ST_WPUL;
          end
        end
        ST_WPUL:
        begin
          cnt <= cnt + 2'h1;
          if (cnt == WPULSE_CNT)
            state <= ST_WEND;
        end
        ST_WEND:
          state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      held <= '0;
    else if (state == ST_IDLE && req_valid)
      held <= req;
  end

  // Enable and strobe are registered so no glitch reaches the pins.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pins   <= '{enable_n: 1'b1, write_n: 1'b1, word_address: '0};
      dq_out <= '0;
      dq_oe  <= 1'b0;
    end
    else
    begin
      if (state == ST_IDLE && req_valid)
        pins.word_address <= req.word_address;
      // Enable rises on the edge that samples read data, so a request
      // taken on the next edge moves the address while deselected.
      // deselect between accesses
      pins.enable_n <= !((state == ST_IDLE && req_valid)
                         || (state == ST_READ && cnt != ACCESS_CNT)
                         || state == ST_WSET
                         || state == ST_WHIZ
                         || state == ST_WPUL);
      pins.write_n <= !(state == ST_WSET || state == ST_WHIZ
                        || (state == ST_WPUL && cnt != WPULSE_CNT));
      if (state == ST_WHIZ && cnt == HIZ_CNT)
      begin
        dq_out <= held.wdata;
        dq_oe  <= 1'b1;
      end
      else if (state == ST_WEND)
        dq_oe <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rdata       <= '0;
      rdata_valid <= 1'b0;
    end
    else
    begin
      rdata_valid <= (state == ST_READ && cnt == ACCESS_CNT);
      if (state == ST_READ && cnt == ACCESS_CNT)
        rdata <= dq_in;
    end
  end

  // no drive while strobe just fell
  AST_NO_EARLY_DRIVE: assert property (@(posedge mclk) disable iff (reset)
    $fell(pins.write_n) |-> !dq_oe) else $error("bus driven at strobe fall");
  AST_ADDR_STABLE: assert property (@(posedge mclk) disable iff (reset)
    !$stable(pins.word_address) |-> $past(pins.enable_n))
    else $error("address moved while selected");
  AST_DATA_HOLD: assert property (@(posedge mclk) disable iff (reset)
    $rose(pins.write_n) && !pins.enable_n |-> dq_oe)
    else $error("data dropped before strobe rise");
  AST_WRITE_LEN: assert property (@(posedge mclk) disable iff (reset)
    $fell(pins.write_n) |-> ##[1:4] pins.write_n)
    else $error("write pulse too long");
  AST_STROBE_SELECTED: assert property (@(posedge mclk) disable iff (reset)
    !pins.write_n |-> !pins.enable_n) else $error("strobe while deselected");
  AST_READ_DONE: assert property (@(posedge mclk) disable iff (reset)
    req_ready && req_valid && !req.write |-> ##[2:4] rdata_valid)
    else $error("read answer late");
endmodule

// >>> verification/ansc_sram_model.sv
`timescale 1ns/1ns
module ansc_sram_model
  import ansc_pkg::*;
(
  input  wire ansc_pkg::ansc_pins_t        pins,
  input  wire logic [ansc_pkg::DATA_W-1:0] dq_out,
  input  wire logic                        dq_oe,
  output logic [ansc_pkg::DATA_W-1:0]      bus
);
  logic [DATA_W-1:0] mem [0:4095];
  logic              drv;
  logic [DATA_W-1:0] q;
  assign drv = !pins.enable_n && pins.write_n;
  assign q = mem[pins.word_address];
  // float, shown as the inverse of the addressed word.
  assign bus = dq_oe ? dq_out : (drv ? q : ~q);
  // write lands on the ending edge.
  always @(posedge pins.write_n or posedge pins.enable_n)
    if (pins.write_n ^ pins.enable_n)
      mem[pins.word_address] <= dq_oe ? dq_out : 'x;
endmodule

// >>> verification/tb_ansc_host.sv
`timescale 1ns/1ns
module tb_ansc_host;
  import ansc_pkg::*;
  logic              mclk = 0;
  logic              reset = 1;
  logic              req_valid = 0;
  ansc_req_t         req = '0;
  logic              req_ready;
  logic              rdata_valid;
  logic              dq_oe;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] dq_in;
  logic [DATA_W-1:0] dq_out;
  ansc_pins_t        pins;
  int                n_mismatch = 0;
  int                comparisons = 0;
  always #50 mclk = ~mclk;
  ansc_host u_ansc_host (.mclk(mclk), .reset(reset), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .rdata(rdata),
    .rdata_valid(rdata_valid), .pins(pins), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe));
  ansc_sram_model u_ansc_sram_model (.pins(pins), .dq_out(dq_out),
    .dq_oe(dq_oe), .bus(dq_in));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [3:0] d);
    @(negedge mclk);
    req = '{w, a, d};
    req_valid = 1;
    while (req_ready !== 1)
      @(negedge mclk);
    @(negedge mclk);
    req_valid = 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [3:0] e);
    xfer(0, a, 4'h0);
    chk(rdata_valid, 0);
    @(negedge mclk);
    chk({rdata_valid, rdata}, {1'b1, e});
  endtask
  task automatic t_idle;
    chk({pins.enable_n, pins.write_n, dq_oe}, 3'h6);
  endtask
  task automatic t_wr_rd;
    xfer(1, 12'h5a3, 4'h9);
    rd(12'h5a3, 4'h9);
    xfer(1, 12'h5a3, 4'h6);
    rd(12'h5a3, 4'h6);
  endtask
  task automatic t_bounds;
    xfer(1, 12'h000, 4'ha);
    xfer(1, 12'hfff, 4'h5);
    rd(12'h000, 4'ha);
    rd(12'hfff, 4'h5);
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    reset = 0;
    t_idle;
    t_wr_rd;
    t_bounds;
    t_idle;
    finish_test;
  end
  initial
  begin
    #200000;
    n_mismatch++;
    finish_test;
  end
endmodule
